// ==== core/hsf_pkg.sv ====
// Constants for the hot-swap hardware-fault supervisor.
// Assumes a single 40 MHz clock and a 32-bit APB register port.
package hsf_pkg;

    localparam int unsigned CLK_HZ          = 40_000_000;

    // Power-on delay after the regulated supply is good
    localparam int unsigned POR_TIME_US     = 10_000;
    localparam int unsigned POR_CYCLES      =
        POR_TIME_US * (CLK_HZ / 1_000_000);

    // Drain-source check timer after a gate turn-off
    localparam int unsigned DS_CHECK_TIME_US = 100;
    localparam int unsigned DS_CHECK_CYCLES  =
        DS_CHECK_TIME_US * (CLK_HZ / 1_000_000);

    // Digitised drop codes from the power-path converter
    localparam int unsigned DROP_W          = 10;
    localparam int unsigned MIN_DROP_CODE   = 32;

    // Register map, byte addresses
    localparam int unsigned ADDR_W          = 8;
    localparam logic [7:0]  STATUS_ADDR     = 8'h00;
    localparam logic [7:0]  DS_CFG_ADDR     = 8'h04;

    // Status field positions
    localparam int unsigned ST_HW_FAULT     = 0;
    localparam int unsigned ST_DS_FAULT     = 1;
    localparam int unsigned ST_SENSE_FAULT  = 2;
    localparam int unsigned ST_CAP_FAULT    = 3;
    localparam int unsigned ST_BREAKER      = 4;
    localparam int unsigned ST_GATE_ON      = 5;
    localparam int unsigned ST_POR_DONE     = 6;
    localparam int unsigned ST_SRC_ARMED    = 7;
    localparam int unsigned ST_SENSE_ARMED  = 8;
    localparam int unsigned ST_DS_RUNNING   = 9;

    // Drain-source check count register
    localparam int unsigned DS_CFG_W        = 16;
    localparam logic [15:0] DS_CFG_RST      = 16'(DS_CHECK_CYCLES);

endpackage

// ==== core/hsf_supervisor.sv ====
// Latched hardware-fault supervisor for a single-FET hot-swap controller.
// Assumes all comparator inputs are filtered and synchronous to i_clk,
// and i_supply_good falls only when the regulated supply drops below
// its lockout-low level (hysteresis lives in the analog front end).
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps

//
// Behaviour
// RQ1: The source monitor is armed while enable is low once supply is good and the power-on delay is over.
// RQ2: An armed source monitor seeing the output above threshold with enable low raises the fault output at once.
// RQ3: Fault output and latched monitor state clear only when the supply drops below lockout-low.
// RQ4: An enable falling edge in steady operation turns gate drive off, weak pull-down on, discharge high and starts the check timer.
// RQ5: At check-timer expiry the fault output is raised if the output is still above the source threshold.
// RQ6: Any of six shutdown faults turns gate drive off, fault pull-down on, discharge high, starts the timer and arms the monitor.
// RQ7: Sense-resistor short detection is armed by an enable rising edge after the power-on delay with gate-source voltage good.
// RQ8: A shorted sense resistor switches inrush control from current slope to gate-voltage slope.
// RQ9: Sense short checking needs a transistor drop above the minimum, with a threshold of half the excess drop.
// RQ10: A resistor drop below that threshold trips the breaker, drops the gate, raises discharge and the fault output.
// RQ11: Before power-up the timing capacitor pin is held discharged.
// RQ12: As the supply rises the timing capacitor is charged from the current source.
// RQ13: A capacitor still below its charged threshold when the power-on delay ends is flagged as shorted.
// RQ14: A shorted timing capacitor raises the fault output without touching gate drive or discharge.
// RQ15: Recovery from a hardware fault needs the service processor to remove main supply.
// RQ16: Analog comparisons arrive as synchronous booleans and the delays are parameters; here the check delay is the APB-written ds_cfg register.
// RQ17: Fault latch, check timer and arm states are held cleared while the supply-good input is low.
module hsf_supervisor
    import hsf_pkg::*;
#(
    // Power-on delay is a parameter, check delay the ds_cfg register; comparators arrive as synchronous flags [RQ16]
    parameter int unsigned POR_COUNT   = hsf_pkg::POR_CYCLES,
    parameter int unsigned DRP_W       = hsf_pkg::DROP_W,
    parameter int unsigned MIN_DROP    = hsf_pkg::MIN_DROP_CODE
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_resetn,
    // APB slave
    input  wire logic                        i_psel,
    input  wire logic                        i_penable,
    input  wire logic                        i_pwrite,
    input  wire logic [hsf_pkg::ADDR_W-1:0]  i_paddr,
    input  wire logic [31:0]                 i_pwdata,
    output logic      [31:0]                 o_prdata,
    output logic                             o_pready,
    output logic                             o_pslverr,
    // Supply and enable
    input  wire logic                        i_supply_good,
    input  wire logic                        i_enable,
    // Comparator inputs
    input  wire logic                        i_source_above_thr,
    input  wire logic                        i_gate_source_good,
    input  wire logic                        i_cap_charged,
    input  wire logic                        i_undervoltage_lockout,
    input  wire logic                        i_overvoltage_protect,
    input  wire logic                        i_primary_overcurrent,
    input  wire logic                        i_secondary_overcurrent,
    input  wire logic                        i_load_sense_open,
    input  wire logic                        i_ground_sense_open,
    // Digitised drops across sense resistor and transistor
    input  wire logic [DRP_W-1:0]            i_sense_drop,
    input  wire logic [DRP_W-1:0]            i_transistor_drop,
    // Outputs
    output logic                             o_hardware_fault_out,
    output logic                             o_discharge_drive_out,
    output logic                             o_gate_drive_en,
    output logic                             o_gate_weak_pulldown,
    output logic                             o_gate_fault_pulldown,
    output logic                             o_gate_slope_mode,
    output logic                             o_breaker_tripped,
    output logic                             o_cap_charge_en,
    output logic                             o_cap_discharge_en
);
    import hsf_pkg::*;

    localparam int unsigned POR_W = $clog2(POR_COUNT + 1);

    logic                rst_meta;
    logic                rst_n;
    logic [POR_W-1:0]    por_cnt;
    logic                por_done;
    logic                enable_q;
    logic                gate_on;
    logic                breaker;
    logic                fault_pd;
    logic                discharge;
    logic [DS_CFG_W-1:0] ds_cfg;
    logic [DS_CFG_W-1:0] ds_cnt;
    logic                ds_running;
    logic                src_armed;
    logic                sense_pend;
    logic                sense_armed;
    logic                ds_fault;
    logic                sense_fault;
    logic                cap_fault;
    logic                slope_gate;
    logic                hw_fault;
    logic [31:0]         prdata;

    logic                en_rise;
    logic                en_fall;
    logic                shutdown;
    logic                shutdown_q;
    logic                shutdown_rise;
    logic                ds_start;
    logic                ds_expire;
    logic                drop_over_min;
    logic [DRP_W-1:0]    sense_thr;
    logic                sense_short;
    logic                src_now_fault;
    logic                gate_start;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Edge copies reset to the idle level, so reset gives no false edge
    assign en_rise  = i_enable & ~enable_q;
    assign en_fall  = ~i_enable & enable_q;
    assign shutdown = i_undervoltage_lockout | i_overvoltage_protect |
                      i_primary_overcurrent | i_secondary_overcurrent |
                      i_load_sense_open | i_ground_sense_open;
    assign shutdown_rise = shutdown & ~shutdown_q;

    // Check timer starts when enable falls or a shutdown fault rises while the gate is on
    assign ds_start  = gate_on & (en_fall | shutdown_rise);   // [RQ4] [RQ6]
    assign ds_expire = ds_running & (ds_cnt == '0);

    // Half the transistor drop in excess of the minimum offset
    assign drop_over_min = i_transistor_drop > DRP_W'(MIN_DROP);  // [RQ9]
    assign sense_thr     = DRP_W'((i_transistor_drop - DRP_W'(MIN_DROP))
                                  >> 1);                          // [RQ9]
    assign sense_short   = sense_armed & gate_on & drop_over_min &
                           (i_sense_drop < sense_thr);            // [RQ10]

    // Immediate source check only while no discharge timing is pending
    assign src_now_fault = src_armed & ~i_enable & ~gate_on &
                           ~ds_running & ~ds_start &
                           i_source_above_thr;                    // [RQ2]

    // A tripped breaker or a sense short refuses a new start
    assign gate_start = en_rise & por_done & ~breaker & ~shutdown &
                        ~sense_fault;

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q   <= 1'b0;
            shutdown_q <= 1'b0;
        end else begin
            enable_q   <= i_enable;
            shutdown_q <= shutdown;
        end
    end

    // Power-on delay, counted only while the supply is good
    // The count stops at its end, so por_done cannot drop while powered
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            por_cnt  <= '0;
            por_done <= 1'b0;
        end else if (!i_supply_good) begin
            por_cnt  <= '0;
            por_done <= 1'b0;
        end else if (!por_done) begin
            if (por_cnt == POR_W'(POR_COUNT - 1)) begin
                por_done <= 1'b1;
            end
            por_cnt <= por_cnt + 1'b1;
        end
    end

    // Gate drive, pull-downs, discharge and breaker
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_on   <= 1'b0;
            breaker   <= 1'b0;
            fault_pd  <= 1'b0;
            discharge <= 1'b0;
        end else if (!i_supply_good) begin
            gate_on   <= 1'b0;
            breaker   <= 1'b0;
            fault_pd  <= 1'b0;
            discharge <= 1'b0;
        end else if (sense_short) begin
            gate_on   <= 1'b0;                                    // [RQ10]
            breaker   <= 1'b1;
            fault_pd  <= 1'b1;
            discharge <= 1'b1;
        end else if (shutdown & (gate_on | ~discharge)) begin
            gate_on   <= 1'b0;                                    // [RQ6]
            fault_pd  <= 1'b1;
            discharge <= 1'b1;
            // Level faults release on their own; latched ones need enable
            if (!(i_undervoltage_lockout | i_overvoltage_protect)) begin
                breaker <= 1'b1;
            end
        end else if (en_fall) begin
            gate_on   <= 1'b0;                                    // [RQ4]
            fault_pd  <= 1'b0;
            discharge <= 1'b1;
            breaker   <= 1'b0;
        end else if (gate_start) begin
            gate_on   <= 1'b1;
            fault_pd  <= 1'b0;
            discharge <= 1'b0;
        end
    end

    // Drain-source check timer
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ds_cnt     <= '0;
            ds_running <= 1'b0;
        end else if (!i_supply_good) begin
            ds_cnt     <= '0;                                     // [RQ17]
            ds_running <= 1'b0;
        end else if (ds_start) begin
            ds_cnt     <= ds_cfg;                                 // [RQ4]
            ds_running <= 1'b1;
        end else if (ds_expire) begin
            ds_running <= 1'b0;
        end else if (ds_running) begin
            ds_cnt <= ds_cnt - 1'b1;
        end
    end

    // Detection arm states
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_armed   <= 1'b0;
            sense_pend  <= 1'b0;
            sense_armed <= 1'b0;
        end else if (!i_supply_good) begin
            src_armed   <= 1'b0;                                  // [RQ17]
            sense_pend  <= 1'b0;
            sense_armed <= 1'b0;
        end else begin
            if ((por_done & ~i_enable) | ds_start) begin
                src_armed <= 1'b1;                                // [RQ1] [RQ6]
            end else if (gate_on) begin
                src_armed <= 1'b0;
            end
            if (gate_start) begin
                sense_pend <= 1'b1;                               // [RQ7]
            end else if (~gate_on) begin
                sense_pend <= 1'b0;
            end
            if (sense_pend & gate_on & i_gate_source_good) begin
                sense_armed <= 1'b1;                              // [RQ7]
            end else if (~gate_on) begin
                sense_armed <= 1'b0;
            end
        end
    end

    // Latched hardware faults; only loss of supply clears them
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ds_fault    <= 1'b0;
            sense_fault <= 1'b0;
            cap_fault   <= 1'b0;
            slope_gate  <= 1'b0;
            hw_fault    <= 1'b0;
        end else if (!i_supply_good) begin
            ds_fault    <= 1'b0;                                  // [RQ3] [RQ17]
            sense_fault <= 1'b0;
            cap_fault   <= 1'b0;
            slope_gate  <= 1'b0;
            hw_fault    <= 1'b0;
        end else begin
            if (src_now_fault |
                (ds_expire & i_source_above_thr)) begin
                ds_fault <= 1'b1;                                 // [RQ2] [RQ5]
            end
            if (sense_short) begin
                sense_fault <= 1'b1;                              // [RQ10]
                slope_gate  <= 1'b1;                              // [RQ8]
            end
            // Sampled at the cycle the power-on delay ends
            if (i_supply_good & ~por_done &
                (por_cnt == POR_W'(POR_COUNT - 1)) & ~i_cap_charged) begin
                cap_fault <= 1'b1;                                // [RQ13]
            end
            if (ds_fault | sense_fault | cap_fault) begin
                hw_fault <= 1'b1;                                 // [RQ14] [RQ3]
            end
        end
    end

    // APB: zero wait states, read data captured in the setup cycle
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ds_cfg <= DS_CFG_RST;
        end else if (i_psel & i_penable & i_pwrite &
                     (i_paddr == DS_CFG_ADDR)) begin
            ds_cfg <= i_pwdata[DS_CFG_W-1:0];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= '0;
        end else if (i_psel & ~i_penable) begin
            prdata <= '0;
            if (i_paddr == STATUS_ADDR) begin
                prdata[ST_HW_FAULT]    <= hw_fault;
                prdata[ST_DS_FAULT]    <= ds_fault;
                prdata[ST_SENSE_FAULT] <= sense_fault;
                prdata[ST_CAP_FAULT]   <= cap_fault;
                prdata[ST_BREAKER]     <= breaker;
                prdata[ST_GATE_ON]     <= gate_on;
                prdata[ST_POR_DONE]    <= por_done;
                prdata[ST_SRC_ARMED]   <= src_armed;
                prdata[ST_SENSE_ARMED] <= sense_armed;
                prdata[ST_DS_RUNNING]  <= ds_running;
            end else if (i_paddr == DS_CFG_ADDR) begin
                prdata[DS_CFG_W-1:0] <= ds_cfg;
            end
        end
    end

    assign o_prdata  = prdata;
    assign o_pready  = 1'b1;
    // Unmapped offsets answer with an error instead of stalling the bus
    assign o_pslverr = i_psel & i_penable &
                       (i_paddr != STATUS_ADDR) & (i_paddr != DS_CFG_ADDR);

    assign o_hardware_fault_out  = hw_fault;
    assign o_discharge_drive_out = discharge;
    assign o_gate_drive_en       = gate_on;
    assign o_gate_weak_pulldown  = ~gate_on & ~fault_pd;          // [RQ4]
    assign o_gate_fault_pulldown = fault_pd;
    assign o_gate_slope_mode     = slope_gate;
    assign o_breaker_tripped     = breaker;
    // Charge toward the regulated rail while it is up, else hold at 0 V
    assign o_cap_charge_en       = i_supply_good;                 // [RQ12]
    assign o_cap_discharge_en    = ~i_supply_good;                // [RQ11]

endmodule

// ==== sim/hsf_checker.sv ====
// Concurrent checks on the hardware-fault supervisor ports.
// Assumes it is bound into hsf_supervisor: one clock, active-low reset.
`timescale 1ns/1ps
module hsf_checker
    import hsf_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic              o_pslverr,
    input  wire logic              i_supply_good,
    input  wire logic              i_enable,
    input  wire logic              o_hardware_fault_out,
    input  wire logic              o_discharge_drive_out,
    input  wire logic              o_gate_drive_en,
    input  wire logic              o_gate_weak_pulldown,
    input  wire logic              o_gate_fault_pulldown,
    input  wire logic              o_gate_slope_mode,
    input  wire logic              o_breaker_tripped,
    input  wire logic              o_cap_charge_en
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    AST_HWF_HOLD: assert property (
        o_hardware_fault_out && i_supply_good |=> o_hardware_fault_out)
        else $error("hardware fault dropped while supply good");
    AST_SUPPLY_CLR: assert property (
        !i_supply_good |=> !o_hardware_fault_out && !o_gate_drive_en
            && !o_breaker_tripped)
        else $error("state not cleared on supply loss");
    AST_CAP_PIN: assert property (
        o_cap_charge_en == i_supply_good)
        else $error("timing cap charge does not follow supply");
    AST_ENA_FALL: assert property (
        $fell(i_enable) && o_gate_drive_en && !o_gate_fault_pulldown
            && i_supply_good |=> !o_gate_drive_en
            && o_discharge_drive_out && o_gate_weak_pulldown)
        else $error("enable fall did not shut the gate");
    AST_BREAKER: assert property (
        $rose(o_breaker_tripped) |-> !o_gate_drive_en
            && o_gate_fault_pulldown && o_discharge_drive_out)
        else $error("breaker trip without gate shutdown");
    AST_SLOPE: assert property (
        $rose(o_gate_slope_mode) && i_supply_good
            |-> o_breaker_tripped ##1 o_hardware_fault_out)
        else $error("sense short without breaker and fault");
    AST_SLOPE_HOLD: assert property (
        o_gate_slope_mode && i_supply_good
            |=> o_gate_slope_mode && !o_gate_drive_en)
        else $error("gate restarted after sense short");
    AST_APB_ERR: assert property (
        i_psel && i_penable && i_paddr != STATUS_ADDR
            && i_paddr != DS_CFG_ADDR |-> o_pslverr)
        else $error("unmapped access without slave error");

    cover property ($rose(o_hardware_fault_out));
    cover property ($rose(o_breaker_tripped) && !o_gate_slope_mode);
    cover property ($rose(o_gate_slope_mode));
endmodule

bind hsf_supervisor hsf_checker hsf_checker_inst (.*);

// ==== sim/hsf_fet_model.sv ====
// Behavioural pass transistor with its channel drop, and timing capacitor.
// Assumes it is driven by the supervisor's gate and charge outputs.
`timescale 1ns/1ps
module hsf_fet_model (
    input  wire logic       i_clk,
    input  wire logic       i_gate_on,
    input  wire logic       i_charge_en,
    input  wire logic       i_ds_short,
    input  wire logic       i_cap_short,
    output logic            o_source_above,
    output logic            o_gate_good,
    output logic            o_cap_charged,
    output logic [9:0]      o_drop
);
    logic [1:0] gate_q = 2'h0;
    logic [2:0] cap_q = 3'h0;
    // Node voltages lag their drives, so no answer to the gate or charge drive is instant
    always @(posedge i_clk) begin
        gate_q <= {gate_q[0], i_gate_on};
        cap_q <= i_charge_en ? {cap_q[1:0], 1'b1} : 3'h0;
    end
    // A shorted channel holds the output up whatever the gate does
    assign o_source_above = i_ds_short | gate_q[0];
    assign o_gate_good = gate_q[1];
    // A shorted pin never reaches the charged level
    assign o_cap_charged = cap_q[2] & ~i_cap_short;
    assign o_drop = gate_q[1] ? 10'h064 : 10'h000;
endmodule

// ==== sim/tb.sv ====
// Self-checking bench for the hardware-fault supervisor.
// Assumes the pass-transistor model and the bound checker.
`timescale 1ns/1ps
module tb;
    import hsf_pkg::*;
    localparam int POR_N = 20;
    localparam int DS_N = 8;
    // Trip level for the model's steady 100-code channel drop
    localparam logic [9:0] THR = (10'h064 - 10'(MIN_DROP_CODE)) >> 1;
    logic i_clk = 1'b0, i_resetn = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
    logic i_pwrite = 1'b0, i_supply_good = 1'b0, i_enable = 1'b0;
    logic [ADDR_W-1:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
    logic [DROP_W-1:0] i_sense_drop = 10'h3FF, i_transistor_drop;
    logic [5:0] flt = 6'h00;
    logic ds_short = 1'b0, cap_short = 1'b0, perr;
    logic o_pready, o_pslverr, o_hardware_fault_out, o_discharge_drive_out;
    logic o_gate_drive_en, o_gate_weak_pulldown, o_gate_fault_pulldown;
    logic o_gate_slope_mode, o_breaker_tripped, o_cap_charge_en;
    logic o_cap_discharge_en, i_source_above_thr, i_gate_source_good;
    logic i_cap_charged, i_undervoltage_lockout, i_overvoltage_protect;
    logic i_primary_overcurrent, i_secondary_overcurrent, i_load_sense_open;
    logic i_ground_sense_open;
    int n_errors = 0, total_checks = 0;
    assign {i_ground_sense_open, i_load_sense_open, i_secondary_overcurrent,
            i_primary_overcurrent, i_overvoltage_protect,
            i_undervoltage_lockout} = flt;

    hsf_supervisor #(.POR_COUNT(POR_N)) hsf_supervisor_inst (.*);
    hsf_fet_model hsf_fet_model_inst (
        .i_clk(i_clk), .i_gate_on(o_gate_drive_en),
        .i_charge_en(o_cap_charge_en), .i_ds_short(ds_short),
        .i_cap_short(cap_short), .o_source_above(i_source_above_thr),
        .o_gate_good(i_gate_source_good), .o_cap_charged(i_cap_charged),
        .o_drop(i_transistor_drop));

    initial begin
        forever #12.5 i_clk = ~i_clk;
    end

    task automatic chk(input string what, input logic [39:0] seen,
                       input logic [39:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h",
                     what, exp, seen);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge i_clk);
        @(negedge i_clk);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= wd;
        @(posedge i_clk);
        i_penable <= 1'b1;
        // Only the watchdog ends a wait for ready
        do begin
            @(posedge i_clk);
        end while (o_pready !== 1'b1);
        rd = o_prdata;
        perr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    // Supply cycle: clears every latch, then a fresh power-on delay
    task automatic pwr(input logic c, input logic s);
        @(posedge i_clk);
        i_supply_good <= 1'b0;
        i_enable <= 1'b0;
        flt <= 6'h00;
        cap_short <= c;
        ds_short <= s;
        i_sense_drop <= 10'h3FF;
        cyc(3);
        chk("clr", o_hardware_fault_out, 1'b0);
        chk("cap_dis", o_cap_discharge_en, 1'b1);
        @(posedge i_clk);
        i_supply_good <= 1'b1;
        cyc(POR_N - 2);
        chk("early", o_hardware_fault_out, 1'b0);
        cyc(8);
        chk("start", o_hardware_fault_out, c | s);
        chk("idle", {o_gate_drive_en, o_discharge_drive_out}, 2'b00);
    endtask

    task automatic en_on();
        int n;
        @(posedge i_clk);
        i_enable <= 1'b1;
        n = 0;
        do begin
            cyc(0);
            n++;
        end while (o_gate_drive_en !== 1'b1 && n < 10);
        chk("gate_on", o_gate_drive_en, 1'b1);
        cyc(4);
    endtask

    task automatic t_regs();
        apb(1'b0, DS_CFG_ADDR, 32'h0);
        chk("cfg_rst", rd, 32'(DS_CFG_RST));
        apb(1'b1, DS_CFG_ADDR, 32'(DS_N));
        apb(1'b0, DS_CFG_ADDR, 32'h0);
        chk("cfg", {perr, rd}, {1'b0, 32'(DS_N)});
        apb(1'b1, 8'h08, 32'hFFFF_FFFF);
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped", {perr, rd}, {1'b1, 32'h0});
        pwr(1'b1, 1'b0);
        apb(1'b1, STATUS_ADDR, 32'hFFFF_FFFF);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk("status", rd[5:0], 6'h09);
    endtask

    // Neither the short going away nor enable toggles may clear it
    task automatic t_latch();
        pwr(1'b0, 1'b1);
        @(posedge i_clk);
        ds_short <= 1'b0;
        i_enable <= 1'b1;
        cyc(DS_N);
        @(posedge i_clk);
        i_enable <= 1'b0;
        cyc(DS_N + 6);
        chk("latched", o_hardware_fault_out, 1'b1);
    endtask

    task automatic t_en_fall(input logic s);
        pwr(1'b0, 1'b0);
        en_on();
        @(posedge i_clk);
        ds_short <= s;
        @(posedge i_clk);
        i_enable <= 1'b0;
        cyc(2);
        chk("off", {o_gate_drive_en, o_discharge_drive_out,
                    o_gate_weak_pulldown}, 3'b011);
        cyc(DS_N);
        chk("ds_wait", o_hardware_fault_out, 1'b0);
        cyc(4);
        chk("ds_end", o_hardware_fault_out, s);
    endtask

    task automatic t_shutdown(input int i);
        pwr(1'b0, 1'b0);
        en_on();
        @(posedge i_clk);
        flt <= 6'h01 << i;
        ds_short <= 1'b1;
        cyc(2);
        chk("sd", {o_gate_drive_en, o_gate_fault_pulldown,
                   o_discharge_drive_out}, 3'b011);
        cyc(DS_N + 4);
        chk("sd_hw", o_hardware_fault_out, 1'b1);
    endtask

    // Drop exactly at the trip level must pass, one code below trips
    task automatic t_sense();
        pwr(1'b0, 1'b0);
        @(posedge i_clk);
        i_sense_drop <= THR;
        en_on();
        cyc(8);
        chk("no_trip", {o_breaker_tripped, o_gate_slope_mode}, 2'b00);
        @(posedge i_clk);
        i_sense_drop <= THR - 10'h001;
        cyc(3);
        chk("trip", {o_breaker_tripped, o_gate_drive_en,
                     o_gate_fault_pulldown, o_discharge_drive_out,
                     o_hardware_fault_out}, 5'h17);
        chk("slope", o_gate_slope_mode, 1'b1);
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (2) @(posedge i_clk);
        t_regs();
        t_latch();
        t_en_fall(1'b0);
        t_en_fall(1'b1);
        for (int i = 0; i < 6; i++) t_shutdown(i);
        t_sense();
        conclude();
    end

    initial begin
        repeat (4000) @(posedge i_clk);
        n_errors++;
        conclude();
    end
endmodule
